// ===== rtl/buck_fault_cfg.svh
// Constants of the buck converter fault supervisor: timing, offsets and fields.
`ifndef BUCK_FAULT_CFG_SVH
`define BUCK_FAULT_CFG_SVH

// ****************************************************************************
// Time base
// ****************************************************************************
`define CLK_PERIOD_NS     4
`define TICK_PERIOD_NS    1000
`define TICK_CYCLES       (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W        8
`define DELAY_CNT_W       12

// ****************************************************************************
// Delays in microseconds and in time base ticks
// ****************************************************************************
`define UV_FILTER_US      30
`define OV_FILTER_US      30
`define RELEASE_US        120
`define HICCUP_US         3500
`define SYNC_LOST_US      8
`define RAMP_STEP_US      8
`define US_TO_TICKS(us)   (((us) * 1000 + `TICK_PERIOD_NS - 1) / `TICK_PERIOD_NS)
`define UV_FILTER_TICKS   `US_TO_TICKS(`UV_FILTER_US)
`define OV_FILTER_TICKS   `US_TO_TICKS(`OV_FILTER_US)
`define RELEASE_TICKS     `US_TO_TICKS(`RELEASE_US)
`define HICCUP_TICKS      `US_TO_TICKS(`HICCUP_US)
`define SYNC_LOST_TICKS   `US_TO_TICKS(`SYNC_LOST_US)
`define RAMP_STEP_TICKS   `US_TO_TICKS(`RAMP_STEP_US)

// ****************************************************************************
// Switching frequency scale in sixteenths of the set frequency
// ****************************************************************************
`define FREQ_FULL         5'h10
`define FREQ_QUARTER      5'h04

// ****************************************************************************
// Comparator vector bit positions
// ****************************************************************************
`define CMP_W             16
`define CMP_MODE_HIGH     0
`define CMP_MODE_LOW      1
`define CMP_LIGHT_LOAD    2
`define CMP_MAX_DUTY      3
`define CMP_VIN_SAG       4
`define CMP_SOFT_START    5
`define CMP_THERMAL       6
`define CMP_FB_UV         7
`define CMP_FB_UV_REL     8
`define CMP_FB_OV         9
`define CMP_FB_OV_REL     10
`define CMP_OVP           11
`define CMP_CUR_LIMIT     12
`define CMP_SHORT         13
`define CMP_REVERSE       14
`define CMP_POWER_OK_PIN  15

// ****************************************************************************
// Register map
// ****************************************************************************
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_FAULTS        8'h08
`define CTRL_RESET        32'h0000_0000
`define CTRL_LATCH_BIT    0
`define STAT_FREQ_LSB     0
`define STAT_SWITCH_BIT   5
`define STAT_UV_BIT       6
`define STAT_OV_BIT       7
`define STAT_PROT_LSB     8
`define STAT_FORCED_BIT   10
`define STAT_SYNC_BIT     11
`define STAT_PIN_BIT      12
`define FAULT_W           7

`endif

// ===== rtl/buck_fault_pkg.sv
// Types shared by the buck converter fault supervisor modules.
`include "buck_fault_cfg.svh"
package buck_fault_pkg;

  typedef enum logic [1:0] {
    PROT_RUN,
    PROT_HICCUP,
    PROT_LATCHED
  } prot_e;

  typedef struct packed {
    logic                      flag;
    logic [`DELAY_CNT_W-1:0]   cnt;
  } filter_state_s;

  typedef struct packed {
    logic [`CMP_W-1:0]         meta;
    logic [`CMP_W-1:0]         cmp;
    logic [`TICK_CNT_W-1:0]    presc;
    logic                      tick;
    logic                      mode_prev;
    logic                      edge_seen;
    logic [3:0]                edge_ticks;
    logic                      sync_active;
    logic                      forced_pwm;
    logic [3:0]                ramp_cnt;
    logic [4:0]                freq_scale;
    prot_e                     prot;
    logic [`DELAY_CNT_W-1:0]   hic_cnt;
    logic                      latch_sel;
    logic [`FAULT_W-1:0]       faults;
    logic                      ap_valid;
    logic                      ap_write;
    logic [7:0]                ap_addr;
    logic [31:0]               hrdata;
    logic                      ready;
    logic                      switch_enable;
    logic                      high_side_off;
    logic                      low_side_off;
    logic                      light_load_freq_mod;
    logic                      switching_clock_synced;
    logic                      power_ok_oe_n;
  } supervisor_state_s;

endpackage

// ===== rtl/qualify_filter.sv
// Level qualifier: a flag that sets and clears only after conditions hold for whole delays.
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_cfg.svh"
module qualify_filter #(
  parameter logic [`DELAY_CNT_W-1:0] SET_TICKS = 12'h01e,
  parameter logic [`DELAY_CNT_W-1:0] CLR_TICKS = 12'h078
) (
  input  wire logic hclk,
  input  wire logic core_rst_n,
  input  wire logic tick,
  input  wire logic set_cond,
  input  wire logic clr_cond,
  output logic      flag
);

  buck_fault_pkg::filter_state_s st;
  buck_fault_pkg::filter_state_s next_st;

  // The running condition must hold without a break; any gap restarts the count.
  always_comb begin
    next_st = st;
    if (!st.flag) begin
      if (!set_cond) begin
        next_st.cnt = '0;
      end else if (tick) begin
        if (st.cnt >= SET_TICKS - 12'h001) begin
          next_st.flag = 1'b1;
          next_st.cnt  = '0;
        end else begin
          next_st.cnt = st.cnt + 12'h001;
        end
      end
    end else begin
      if (!clr_cond) begin
        next_st.cnt = '0;
      end else if (tick) begin
        if (st.cnt >= CLR_TICKS - 12'h001) begin
          next_st.flag = 1'b0;
          next_st.cnt  = '0;
        end else begin
          next_st.cnt = st.cnt + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

endmodule
`default_nettype wire

// ===== rtl/buck_fault_supervisor.sv
// Supervisory, mode and protection sequencing of a step-down converter controller.
//
// What this block does
// - Mode input high forces PWM, low selects auto.
// - Auto mode picks light-load modulation by load.
// - External clock on mode input locks, forces PWM.
// - Synchronization runs alongside soft-start, never deferred.
// - Duty exhaustion drops sync, slows to quarter.
// - Input sag ramps frequency linearly to quarter.
// - Power-good pulled low under any listed condition.
// - Power-good released once all conditions clear.
// - Under-voltage flagged after filter time below threshold.
// - Under-voltage cleared after release delay above threshold.
// - Fault during under-voltage enters hiccup or latch.
// - Feedback over-voltage stops switching, filtered power-good low.
// - Over-voltage release delay restores power-good and switching.
// - Output-pin over-voltage suspends switching while asserted.
// - Under-voltage during output-pin over-voltage triggers protection.
// - Latch holds until enable low or lockout.
// - Hiccup stops, restarts after delay, repeats on fault.
// - Current limit turns high-side switch off promptly.
// - Switch-node short detected independent of current limit.
// - Reverse current in forced mode turns low-side off.
`timescale 1ns/1ps
`default_nettype none
`include "buck_fault_cfg.svh"
module buck_fault_supervisor (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        chip_enable,
  input  wire logic        supply_lockout,
  input  wire logic        mode_above_high,
  input  wire logic        mode_below_low,
  input  wire logic        light_load,
  input  wire logic        max_duty,
  input  wire logic        vin_sag,
  input  wire logic        soft_start_active,
  input  wire logic        thermal_shutdown,
  input  wire logic        fb_below_uv,
  input  wire logic        fb_above_uv_release,
  input  wire logic        fb_above_ov,
  input  wire logic        fb_below_ov_release,
  input  wire logic        output_pin_overvoltage,
  input  wire logic        current_limit_trip,
  input  wire logic        short_to_supply,
  input  wire logic        short_to_ground,
  input  wire logic        reverse_current_trip,
  input  wire logic        power_ok_in,
  output logic             power_ok_out,
  output logic             power_ok_out_oe_n,
  output logic             switch_enable,
  output logic             high_side_off,
  output logic             low_side_off,
  output logic             forced_pwm,
  output logic             light_load_freq_mod,
  output logic             switching_clock_synced,
  output logic [4:0]       freq_scale
);

  // ****************************************************************************
  // Reset and comparator collection
  // ****************************************************************************

  logic                    core_rst_n;
  logic [`CMP_W-1:0]       raw_cmp;
  logic                    uv_flag;
  logic                    ov_flag;
  buck_fault_pkg::supervisor_state_s st;
  buck_fault_pkg::supervisor_state_s next_st;

  // Enable low or lockout resets all state at once, bus registers included; freq_scale reloads full rate.
  assign core_rst_n = hresetn & chip_enable & ~supply_lockout;

  assign raw_cmp = {power_ok_in, reverse_current_trip, short_to_supply | short_to_ground,
                    current_limit_trip, output_pin_overvoltage, fb_below_ov_release,
                    fb_above_ov, fb_above_uv_release, fb_below_uv, thermal_shutdown,
                    soft_start_active, vin_sag, max_duty, light_load, mode_below_low,
                    mode_above_high};

  // ****************************************************************************
  // Feedback window qualifiers
  // ****************************************************************************

  qualify_filter #(
    .SET_TICKS (12'(`UV_FILTER_TICKS)),
    .CLR_TICKS (12'(`RELEASE_TICKS))
  ) u_uv_filter (
    .hclk       (hclk),
    .core_rst_n (core_rst_n),
    .tick       (st.tick),
    .set_cond   (st.cmp[`CMP_FB_UV]),
    .clr_cond   (st.cmp[`CMP_FB_UV_REL]),
    .flag       (uv_flag)
  );

  qualify_filter #(
    .SET_TICKS (12'(`OV_FILTER_TICKS)),
    .CLR_TICKS (12'(`RELEASE_TICKS))
  ) u_ov_filter (
    .hclk       (hclk),
    .core_rst_n (core_rst_n),
    .tick       (st.tick),
    .set_cond   (st.cmp[`CMP_FB_OV]),
    .clr_cond   (st.cmp[`CMP_FB_OV_REL]),
    .flag       (ov_flag)
  );

  // ****************************************************************************
  // Register decode
  // ****************************************************************************

  // Maps a byte address to a register slot; slot 3 is unmapped.
  function automatic logic [1:0] reg_slot(input logic [7:0] addr);
    logic [1:0] slot;
    slot = 2'h3;
    if (addr == `REG_CTRL) begin
      slot = 2'h0;
    end else if (addr == `REG_STATUS) begin
      slot = 2'h1;
    end else if (addr == `REG_FAULTS) begin
      slot = 2'h2;
    end
    return slot;
  endfunction

  // ****************************************************************************
  // Next state
  // ****************************************************************************

  always_comb begin
    logic                mode_rise;
    logic                stretch;
    logic                fault_trig;
    logic                ap_take;
    logic [`FAULT_W-1:0] fault_clr;
    logic [`FAULT_W-1:0] fault_set;
    logic [31:0]         rd_word;
    mode_rise  = 1'b0;
    stretch    = 1'b0;
    fault_trig = 1'b0;
    ap_take    = 1'b0;
    fault_clr  = '0;
    fault_set  = '0;
    rd_word    = 32'h0000_0000;
    next_st    = st;

    // Comparators pass two flip-flops before any use.
    next_st.meta = raw_cmp;
    next_st.cmp  = st.meta;

    // Microsecond time base for every filter, release and protection delay.
    next_st.tick = 1'b0;
    if (st.presc == `TICK_CNT_W'(`TICK_CYCLES - 1)) begin
      next_st.presc = '0;
      next_st.tick  = 1'b1;
    end else begin
      next_st.presc = st.presc + 8'h01;
    end

    // Clock detection on the mode input: two rising edges within the window lock.
    // Detection never looks at soft-start, so both proceed together.
    next_st.mode_prev = st.cmp[`CMP_MODE_HIGH];
    mode_rise = st.cmp[`CMP_MODE_HIGH] & ~st.mode_prev;
    if (mode_rise) begin
      next_st.sync_active = st.edge_seen;
      next_st.edge_seen   = 1'b1;
      next_st.edge_ticks  = '0;
    end else if (st.tick && st.edge_seen) begin
      if (st.edge_ticks == 4'(`SYNC_LOST_TICKS - 1)) begin
        next_st.edge_seen   = 1'b0;
        next_st.sync_active = 1'b0;
      end else begin
        next_st.edge_ticks = st.edge_ticks + 4'h1;
      end
    end

    // Level mode keeps its last choice between the two thresholds.
    if (next_st.sync_active) begin
      next_st.forced_pwm = 1'b1;
    end else if (st.cmp[`CMP_MODE_HIGH]) begin
      next_st.forced_pwm = 1'b1;
    end else if (st.cmp[`CMP_MODE_LOW]) begin
      next_st.forced_pwm = 1'b0;
    end

    // Frequency stretch: one step of a sixteenth per ramp interval, floored at a quarter.
    stretch = st.cmp[`CMP_MAX_DUTY] | st.cmp[`CMP_VIN_SAG];
    if (st.tick) begin
      if (st.ramp_cnt == 4'(`RAMP_STEP_TICKS - 1)) begin
        next_st.ramp_cnt = '0;
        if (stretch && st.freq_scale > `FREQ_QUARTER) begin
          next_st.freq_scale = st.freq_scale - 5'h01;
        end else if (!stretch && st.freq_scale < `FREQ_FULL) begin
          next_st.freq_scale = st.freq_scale + 5'h01;
        end
      end else begin
        next_st.ramp_cnt = st.ramp_cnt + 4'h1;
      end
    end
    next_st.switching_clock_synced = next_st.sync_active & ~stretch &
                                     (st.freq_scale == `FREQ_FULL);

    // Protection entry: any of these events while under-voltage is flagged.
    fault_trig = uv_flag & (st.cmp[`CMP_CUR_LIMIT] | st.cmp[`CMP_SHORT] |
                            st.cmp[`CMP_OVP]);
    unique case (st.prot)
      buck_fault_pkg::PROT_RUN: begin
        if (fault_trig) begin
          next_st.prot    = st.latch_sel ? buck_fault_pkg::PROT_LATCHED
                                         : buck_fault_pkg::PROT_HICCUP;
          next_st.hic_cnt = '0;
        end
      end
      buck_fault_pkg::PROT_HICCUP: begin
        if (st.tick) begin
          if (st.hic_cnt == `DELAY_CNT_W'(`HICCUP_TICKS - 1)) begin
            next_st.prot = buck_fault_pkg::PROT_RUN;
          end else begin
            next_st.hic_cnt = st.hic_cnt + 12'h001;
          end
        end
      end
      buck_fault_pkg::PROT_LATCHED: begin
        next_st.prot = buck_fault_pkg::PROT_LATCHED;
      end
      default: begin
        next_st.prot = buck_fault_pkg::PROT_LATCHED;
      end
    endcase

    // Switching permission and gate overrides.
    next_st.switch_enable = (st.prot == buck_fault_pkg::PROT_RUN) & ~fault_trig &
                            ~st.cmp[`CMP_THERMAL] & ~st.cmp[`CMP_FB_OV] & ~ov_flag &
                            ~st.cmp[`CMP_OVP];
    next_st.high_side_off = st.cmp[`CMP_CUR_LIMIT] | st.cmp[`CMP_SHORT];
    next_st.low_side_off  = st.cmp[`CMP_REVERSE] & st.forced_pwm;
    next_st.light_load_freq_mod = ~next_st.forced_pwm & st.cmp[`CMP_LIGHT_LOAD] &
                                  next_st.switch_enable;

    // Open-drain power-good: enable low and lockout pull it through reset.
    next_st.power_ok_oe_n = ~(st.cmp[`CMP_SOFT_START] | st.cmp[`CMP_THERMAL] | uv_flag |
                              ov_flag | (st.prot != buck_fault_pkg::PROT_RUN));

    // Bus slave: zero wait states, read data loaded at the address phase.
    ap_take          = hsel & htrans[1] & hready;
    next_st.ap_valid = ap_take;
    next_st.ap_write = hwrite;
    next_st.ap_addr  = haddr[7:0];
    if (st.ap_valid && st.ap_write) begin
      unique case (reg_slot(st.ap_addr))
        2'h0:    next_st.latch_sel = hwdata[`CTRL_LATCH_BIT];
        2'h2:    fault_clr = hwdata[`FAULT_W-1:0];
        default: fault_clr = '0;
      endcase
    end
    // A fault event in the clearing cycle stays set.
    fault_set = {st.cmp[`CMP_OVP], st.cmp[`CMP_SHORT], st.cmp[`CMP_CUR_LIMIT],
                 st.prot == buck_fault_pkg::PROT_LATCHED,
                 st.prot == buck_fault_pkg::PROT_HICCUP, ov_flag, uv_flag};
    next_st.faults = (st.faults & ~fault_clr) | fault_set;

    if (ap_take && !hwrite) begin
      unique case (reg_slot(haddr[7:0]))
        2'h0: rd_word[`CTRL_LATCH_BIT] = st.latch_sel;
        2'h1: begin
          rd_word[`STAT_FREQ_LSB +: 5]  = st.freq_scale;
          rd_word[`STAT_SWITCH_BIT]     = st.switch_enable;
          rd_word[`STAT_UV_BIT]         = uv_flag;
          rd_word[`STAT_OV_BIT]         = ov_flag;
          rd_word[`STAT_PROT_LSB +: 2]  = st.prot;
          rd_word[`STAT_FORCED_BIT]     = st.forced_pwm;
          rd_word[`STAT_SYNC_BIT]       = st.sync_active;
          rd_word[`STAT_PIN_BIT]        = st.cmp[`CMP_POWER_OK_PIN];
        end
        2'h2:    rd_word[`FAULT_W-1:0] = st.faults;
        default: rd_word = 32'h0000_0000;
      endcase
      next_st.hrdata = rd_word;
    end
    next_st.ready = 1'b1;
  end

  always_ff @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st            <= '0;
      st.ready      <= 1'b1;
      st.freq_scale <= `FREQ_FULL;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************

  assign hrdata                 = st.hrdata;
  assign hreadyout              = st.ready;
  assign hresp                  = 1'b0;
  assign power_ok_out           = 1'b0;
  assign power_ok_out_oe_n      = st.power_ok_oe_n;
  assign switch_enable          = st.switch_enable;
  assign high_side_off          = st.high_side_off;
  assign low_side_off           = st.low_side_off;
  assign forced_pwm             = st.forced_pwm;
  assign light_load_freq_mod    = st.light_load_freq_mod;
  assign switching_clock_synced = st.switching_clock_synced;
  assign freq_scale             = st.freq_scale;

  // ****************************************************************************
  // Assertions
  // ****************************************************************************

  default clocking dc @(posedge hclk); endclocking
  default disable iff (!core_rst_n);

  sequence s_uv_event;
    uv_flag && (st.cmp[`CMP_CUR_LIMIT] || st.cmp[`CMP_SHORT] || st.cmp[`CMP_OVP]);
  endsequence

  sequence s_run_idle;
    st.prot == buck_fault_pkg::PROT_RUN;
  endsequence

  a_fault_to_hiccup: assert property (s_run_idle ##0 s_uv_event ##0 !st.latch_sel
    |=> st.prot == buck_fault_pkg::PROT_HICCUP ##0 st.hic_cnt == 12'h000)
    else $error("fault under uv did not enter hiccup");
  a_fault_to_latch: assert property (s_run_idle ##0 s_uv_event ##0 st.latch_sel
    |=> st.prot == buck_fault_pkg::PROT_LATCHED ##1 !st.switch_enable)
    else $error("fault under uv did not latch");
  a_latch_holds: assert property (st.prot == buck_fault_pkg::PROT_LATCHED
    |=> st.prot == buck_fault_pkg::PROT_LATCHED && st.power_ok_oe_n == 1'b0)
    else $error("latch released without reset");
  a_hiccup_restart: assert property (st.prot == buck_fault_pkg::PROT_HICCUP && st.tick &&
    st.hic_cnt == 12'(`HICCUP_TICKS - 1) |=> s_run_idle)
    else $error("hiccup did not restart after delay");
  a_hiccup_hold: assert property ($rose(st.prot == buck_fault_pkg::PROT_HICCUP)
    |-> st.hic_cnt == 12'h000 ##1 !st.switch_enable [*3])
    else $error("hiccup did not stop switching");
  a_power_ok_out_fault: assert property (uv_flag || ov_flag
    |=> !st.power_ok_oe_n)
    else $error("power good not pulled low");
  a_power_ok_out_free: assert property (!st.cmp[`CMP_SOFT_START] && !st.cmp[`CMP_THERMAL] &&
    !uv_flag && !ov_flag && st.prot == buck_fault_pkg::PROT_RUN |=> st.power_ok_oe_n)
    else $error("power good held low without cause");
  a_ov_stop: assert property (st.cmp[`CMP_FB_OV] || st.cmp[`CMP_OVP]
    |=> !st.switch_enable)
    else $error("switching during over-voltage");
  a_sync_forced: assert property ($rose(st.sync_active) |-> st.forced_pwm
    ##1 st.forced_pwm || !st.sync_active)
    else $error("synchronized without forced pwm");
  a_freq_floor: assert property (st.freq_scale >= `FREQ_QUARTER &&
    st.freq_scale <= `FREQ_FULL)
    else $error("frequency scale out of range");
  a_stretch_nosync: assert property (st.cmp[`CMP_MAX_DUTY]
    |=> !st.switching_clock_synced)
    else $error("clock stayed synchronized at max duty");
  a_hs_limit: assert property (st.cmp[`CMP_CUR_LIMIT] && !st.cmp[`CMP_SHORT]
    |=> st.high_side_off)
    else $error("high side not turned off on limit");
  a_rev_lowside: assert property (st.cmp[`CMP_REVERSE] && st.forced_pwm
    |=> st.low_side_off)
    else $error("low side not turned off on reverse current");

endmodule
`default_nettype wire

// ===== tb/sync_clock_source.sv
// Far-side model: the external clock that is applied to the mode comparator.
`timescale 1ns/1ps
`default_nettype none
module sync_clock_source #(parameter int HALF_NS = 1000) (
  input  wire logic run,
  output logic      clk_out
);
  // Pulses of about 1 us keep the minimum width and sit inside the lock band.
  always #(HALF_NS) clk_out = run ? ~clk_out : 1'h0;
endmodule
`default_nettype wire

// ===== tb/buck_fault_supervisor_tb.sv
// Self-checking bench of the buck converter fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module buck_fault_supervisor_tb;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, supply_lockout = 0, mode_hi = 0;
  logic        sync_run = 0, mode_below_low = 0, light_load = 0, max_duty = 0, vin_sag = 0;
  logic        soft_start_active = 0, fb_below_uv = 0, fb_above_uv_release = 1;
  logic        fb_above_ov = 0, fb_below_ov_release = 1, output_pin_overvoltage = 0;
  logic        current_limit_trip = 0, short_to_supply = 0, reverse_current_trip = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]  htrans = 0;
  logic        hready, hreadyout, hresp, power_ok_in, power_ok_out, power_ok_out_oe_n;
  logic        switch_enable, high_side_off, low_side_off, forced_pwm, light_load_freq_mod;
  logic        switching_clock_synced, sync_clk, mode_above_high;
  logic        thermal_shutdown = 0, short_to_ground = 0, chip_enable = 1;
  logic [4:0]  freq_scale;
  int          n_fail = 0, num_checks = 0;
  always #2 hclk = ~hclk;
  assign hready = hreadyout;
  // The power-good pin has a pull-up, so a released pin reads high.
  assign power_ok_in = power_ok_out_oe_n ? 1'h1 : power_ok_out;
  assign mode_above_high = sync_run ? sync_clk : mode_hi;
  buck_fault_supervisor i_buck_fault_supervisor (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .chip_enable,
    .supply_lockout, .mode_above_high, .mode_below_low, .light_load, .max_duty, .vin_sag,
    .soft_start_active, .thermal_shutdown, .fb_below_uv, .fb_above_uv_release,
    .fb_above_ov, .fb_below_ov_release, .output_pin_overvoltage, .current_limit_trip,
    .short_to_supply, .short_to_ground, .reverse_current_trip, .power_ok_in,
    .power_ok_out, .power_ok_out_oe_n, .switch_enable, .high_side_off, .low_side_off,
    .forced_pwm, .light_load_freq_mod, .switching_clock_synced, .freq_scale);
  sync_clock_source i_sync_clock_source (.run(sync_run), .clk_out(sync_clk));
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk) {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, w, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    {htrans, hwdata} <= {2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
    hsel <= 1'h0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Frequency scale after a number of slow-down steps from full rate.
  function automatic logic [4:0] slowed(input int steps);
    return (steps >= 12) ? 5'h04 : 5'(16 - steps);
  endfunction
  initial begin
    wt(95000);
    chk(32'h0, 32'h1);
    test_done;
  end
  initial begin
    void'($urandom(19307));
    wt(16);
    chk(power_ok_out_oe_n, 1'h0);
    @(negedge hclk) hresetn = 1'h1;
    wt(12);
    chk(freq_scale, 5'h10);
    chk(power_ok_in, 1'h1);
    $display("reset test done");
    {thermal_shutdown, mode_hi, reverse_current_trip, current_limit_trip} <= 4'hf;
    wt(5);
    chk(forced_pwm, 1'h1);
    chk(low_side_off, 1'h1);
    chk(high_side_off, 1'h1);
    chk({switch_enable, power_ok_out_oe_n}, 2'h0);
    {thermal_shutdown, mode_hi, mode_below_low, light_load, current_limit_trip} <= 5'h06;
    wt(5);
    chk(forced_pwm, 1'h0);
    chk(light_load_freq_mod, 1'h1);
    {soft_start_active, mode_below_low, sync_run} <= 3'h5;
    wt(1500);
    chk(switching_clock_synced, 1'h1);
    chk({forced_pwm, power_ok_out_oe_n}, 2'h2);
    {max_duty, vin_sag, soft_start_active} <= 3'h6;
    wt(750);
    chk(switching_clock_synced, 1'h0);
    $display("mode test done");
    bus(1'h1, 32'h0, $urandom | 32'h1);
    bus(1'h0, 32'h0, 32'h0);
    chk(r[0], 1'h1);
    chk({hresp, power_ok_out}, 2'h0);
    bus(1'h0, 32'($urandom_range(4, 63)) << 2, 32'h0);
    chk(r, 32'h0);
    {fb_above_uv_release, fb_below_uv} <= 2'h1;
    wt(28 * 250);
    chk(power_ok_out_oe_n, 1'h1);
    wt(3 * 250);
    chk(power_ok_out_oe_n, 1'h0);
    {short_to_supply, short_to_ground} <= 2'($urandom_range(1, 2));
    wt(5);
    bus(1'h0, 32'h8, 32'h0);
    chk({r[5], r[3]}, 2'h3);
    {short_to_supply, short_to_ground, fb_above_uv_release, fb_below_uv} <= 4'h2;
    wt(115 * 250);
    bus(1'h0, 32'h4, 32'h0);
    chk(r[9:6], 4'h9);
    bus(1'h1, 32'h8, 32'h7f);
    bus(1'h0, 32'h8, 32'h0);
    chk(r[6:0], 7'h09);
    wt(12 * 250);
    bus(1'h0, 32'h4, 32'h0);
    chk({r[9:5], power_ok_out_oe_n}, 6'h20);
    @(negedge hclk) supply_lockout = 1'h1;
    wt(2);
    @(negedge hclk) supply_lockout = 1'h0;
    wt(8);
    bus(1'h0, 32'h4, 32'h0);
    chk(r[9:8], 2'h0);
    {output_pin_overvoltage, fb_above_uv_release, fb_below_uv} <= 3'h5;
    wt(31 * 250);
    bus(1'h0, 32'h4, 32'h0);
    chk({r[9:5], switch_enable}, 6'h14);
    {output_pin_overvoltage, fb_above_uv_release, fb_below_uv} <= 3'h2;
    @(negedge hclk) chip_enable = 1'h0;
    wt(2);
    @(negedge hclk) chip_enable = 1'h1;
    wt(8);
    $display("protection test done");
    output_pin_overvoltage <= 1'h1;
    wt(5);
    chk(switch_enable, 1'h0);
    {output_pin_overvoltage, fb_above_ov, fb_below_ov_release} <= 3'h2;
    wt(5);
    chk(switch_enable, 1'h0);
    wt(33 * 250);
    chk(power_ok_out_oe_n, 1'h0);
    {fb_above_ov, fb_below_ov_release} <= 2'h1;
    wt(126 * 250);
    chk({power_ok_out_oe_n, switch_enable}, 2'h3);
    chk(freq_scale, slowed(20));
    $display("over-voltage test done");
    test_done;
  end
endmodule
`default_nettype wire
